// [audio_engine_consts.svh]
// register offsets, reset values and timing figures of the audio engine
`ifndef AUDIO_ENGINE_CONSTS_SVH
`define AUDIO_ENGINE_CONSTS_SVH
`define OFS_EFFECT_SELECT   13'h0000
`define OFS_EFFECT_PLAY     13'h0004
`define OFS_EFFECT_VOLUME   13'h0008
`define OFS_PB_START        13'h000C
`define OFS_PB_LENGTH       13'h0010
`define OFS_PB_RATE         13'h0014
`define OFS_PB_FORMAT       13'h0018
`define OFS_PB_LOOP         13'h001C
`define OFS_PB_TRIGGER      13'h0020
`define OFS_PB_VOLUME       13'h0024
`define OFS_PB_FETCH_PTR    13'h0028
`define RAM_SELECT_BIT      12
`define VOLUME_RESET        8'hFF
`define RESP_OKAY           2'b00
`define RESP_DECERR         2'b11
`define CODE_SILENCE        8'h00
`define CODE_PITCH_MAX      8'h3F
`define FIXED_TONE_INC      24'h0000DC
`define CLK_HZ              40000000
`define EFFECT_TIME_MS      250
`define ADPCM_IDX_MAX       7'h58
`endif

// [audio_engine_pkg.sv]
// types shared by the audio engine: sample formats and the engine state record
package audio_engine_pkg;
	typedef enum logic [1:0] {
		format_pcm8   = 2'b00,
		format_mulaw8 = 2'b01,
		format_adpcm4 = 2'b10
	} format_t;

	typedef struct packed {
		logic signed [15:0] pred;
		logic        [6:0]  idx;
	} adpcm_t;

	typedef struct packed {
		logic               awready;
		logic               wready;
		logic               bvalid;
		logic               arready;
		logic               rvalid;
		logic        [1:0]  bresp;
		logic        [1:0]  rresp;
		logic        [31:0] rdata;
		logic               aw_got;
		logic               w_got;
		logic        [12:0] waddr;
		logic        [31:0] wdata;
		logic        [3:0]  wstrb;
		logic        [15:0] effect_select;
		logic               effect_play;
		logic        [7:0]  effect_volume;
		logic        [31:0] pb_start;
		logic        [31:0] pb_length;
		logic        [31:0] pb_rate;
		format_t            pb_format;
		logic               pb_loop;
		logic               pb_active;
		logic        [7:0]  pb_volume;
		logic        [31:0] ptr;
		logic        [31:0] remaining;
		logic        [31:0] rate_acc;
		logic               nibble_hi;
		adpcm_t             adpcm;
		logic signed [7:0]  pb_sample;
		logic        [23:0] phase;
		logic        [31:0] effect_timer;
		logic signed [7:0]  synth_sample;
		logic        [7:0]  pwm_cnt;
		logic        [7:0]  pwm_level;
		logic               pwm_out;
	} engine_state_t;
endpackage

// [audio_engine.sv]
// audio engine: axi4-lite registers, sample ram, effect synth, playback decoder, pwm
`timescale 1ns/1ps
`default_nettype none
`include "audio_engine_consts.svh"

// Operation
// - mix both sources onto one pwm pin
// - play write of 1 starts selected effect
// - play reads 1 while effect runs
// - pitched effects repeat until stopped
// - new code cuts effect; code 0 silences
// - effect volume scales synth amplitude
// - effect select 16 bits, code low byte
// - high byte is note, zero middle C
// - fixed effects ignore the high byte
// - playback fetch begins at start address
// - length counts bytes consumed per clip
// - samples emitted at programmed hertz rate
// - format selects linear, mu-law or adpcm
// - loop 0 plays once, 1 repeats
// - host fills ram, any trigger write starts unless length is 0
// - trigger reads 1 while playback active
// - playback volume 0 to 255 scales
// - decode pcm8, mu-law8 and ima adpcm4
// - adpcm low nibble before high nibble
// - fetch pointer readable at any time
module audio_engine #(
	parameter int RAM_BYTES     = 4096,
	parameter int CLK_HZ        = `CLK_HZ,
	parameter int EFFECT_CYCLES = `EFFECT_TIME_MS * (`CLK_HZ / 1000)
) (
	input  wire logic        aclk,      // 40 MHz system clock
	input  wire logic        aresetn,   // synchronous reset, active low
	input  wire logic [12:0] awaddr,    // write address
	input  wire logic [2:0]  awprot,    // unused protection bits
	input  wire logic        awvalid,   // write address valid
	output var  logic        awready,   // write address ready
	input  wire logic [31:0] wdata,     // write data
	input  wire logic [3:0]  wstrb,     // byte strobes
	input  wire logic        wvalid,    // write data valid
	output var  logic        wready,    // write data ready
	output var  logic [1:0]  bresp,     // write response
	output var  logic        bvalid,    // write response valid
	input  wire logic        bready,    // write response ready
	input  wire logic [12:0] araddr,    // read address
	input  wire logic [2:0]  arprot,    // unused protection bits
	input  wire logic        arvalid,   // read address valid
	output var  logic        arready,   // read address ready
	output var  logic [31:0] rdata,     // read data
	output var  logic [1:0]  rresp,     // read response
	output var  logic        rvalid,    // read data valid
	input  wire logic        rready,    // read data ready
	output var  logic        audio_pwm  // mono pwm audio pin
);
	localparam int RAM_AW = $clog2(RAM_BYTES);
	localparam logic [31:0] CLK_HZ_W = 32'(CLK_HZ);
	localparam logic [31:0] EFFECT_LEN = 32'(EFFECT_CYCLES);
	localparam logic [15:0] ADPCM_STEP [89] = '{
		16'h0007, 16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h000C, 16'h000D, 16'h000E,
		16'h0010, 16'h0011, 16'h0013, 16'h0015, 16'h0017, 16'h0019, 16'h001C, 16'h001F,
		16'h0022, 16'h0025, 16'h0029, 16'h002D, 16'h0032, 16'h0037, 16'h003C, 16'h0042,
		16'h0049, 16'h0050, 16'h0058, 16'h0061, 16'h006B, 16'h0076, 16'h0082, 16'h008F,
		16'h009D, 16'h00AD, 16'h00BE, 16'h00D1, 16'h00E6, 16'h00FD, 16'h0117, 16'h0133,
		16'h0151, 16'h0173, 16'h0198, 16'h01C1, 16'h01EE, 16'h0220, 16'h0256, 16'h0292,
		16'h02D4, 16'h031C, 16'h036C, 16'h03C3, 16'h0424, 16'h048E, 16'h0502, 16'h0583,
		16'h0610, 16'h06AB, 16'h0756, 16'h0812, 16'h08E0, 16'h09C3, 16'h0ABD, 16'h0BD0,
		16'h0CFF, 16'h0E4C, 16'h0FBA, 16'h114C, 16'h1307, 16'h14EE, 16'h1706, 16'h1954,
		16'h1BDC, 16'h1EA5, 16'h21B6, 16'h2515, 16'h28CA, 16'h2CDF, 16'h315B, 16'h364B,
		16'h3BB9, 16'h41B2, 16'h4844, 16'h4F7E, 16'h5771, 16'h602F, 16'h69CE, 16'h7462,
		16'h7FFF
	};
	localparam logic [7:0] NOTE_BASE [16] = '{8'h6E, 8'h75, 8'h7C, 8'h83, 8'h8B, 8'h93,
		8'h9C, 8'hA5, 8'hAF, 8'hB9, 8'hC4, 8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hD0};
	localparam logic [7:0] SINE_MAG [8] = '{8'h00, 8'h31, 8'h5A, 8'h75, 8'h7F, 8'h75,
		8'h5A, 8'h31};
	audio_engine_pkg::engine_state_t r_reg;
	audio_engine_pkg::engine_state_t r_next;
	logic [31:0] mem [RAM_BYTES/4];
	logic        mem_we;
	// byte-lane merge used by the select, effect volume, start, length, rate and play writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				m[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return m;
	endfunction
	// phase step for a midi note, zero being middle C
	function automatic logic [23:0] note_inc(input logic [7:0] note);
		logic [7:0]  n;
		logic [3:0]  oct;
		logic [23:0] base;
		n = note;
		oct = 4'h0;
		for (int i = 0; i < 21; i++) begin
			if (n >= 8'h0C) begin
				n = n - 8'h0C;
				oct = oct + 4'h1;
			end
		end
		base = {16'h0000, NOTE_BASE[n[3:0]]};
		return base << oct;
	endfunction
	// sine table, 16 points a period, built from a quarter-symmetric half
	function automatic logic signed [7:0] sine16(input logic [3:0] p);
		logic [7:0] mag;
		mag = SINE_MAG[p[2:0]];
		return p[3] ? -$signed(mag) : $signed(mag);
	endfunction
	// g.711 mu-law expansion, top byte of the 16-bit result kept
	function automatic logic signed [7:0] mulaw(input logic [7:0] b);
		logic [7:0]  u;
		logic [15:0] t;
		u = ~b;
		t = ({9'h000, u[3:0], 3'h0} + 16'h0084) << u[6:4];
		t = u[7] ? (16'h0084 - t) : (t - 16'h0084);
		return $signed(t[15:8]);
	endfunction
	// one ima adpcm step: predictor and step index updated for a nibble
	function automatic audio_engine_pkg::adpcm_t adpcm(input audio_engine_pkg::adpcm_t s,
		input logic [3:0] nib);
		audio_engine_pkg::adpcm_t o;
		logic [16:0]        step;
		logic [16:0]        diff;
		logic signed [17:0] p;
		logic signed [8:0]  ix;
		step = {1'b0, ADPCM_STEP[s.idx]};
		diff = step >> 3;
		if (nib[2]) diff = diff + step;
		if (nib[1]) diff = diff + (step >> 1);
		if (nib[0]) diff = diff + (step >> 2);
		p = nib[3] ? ({{2{s.pred[15]}}, s.pred} - $signed({1'b0, diff}))
			: ({{2{s.pred[15]}}, s.pred} + $signed({1'b0, diff}));
		if (p > 18'sh07FFF) p = 18'sh07FFF;
		if (p < -18'sh08000) p = -18'sh08000;
		o.pred = p[15:0];
		ix = $signed({2'b00, s.idx}) + (nib[2] ? $signed({5'h00, nib[1:0], 1'b0} + 9'h002)
			: -9'sh001);
		if (ix < 9'sh000) ix = 9'sh000;
		if (ix > $signed({2'b00, `ADPCM_IDX_MAX})) ix = $signed({2'b00, `ADPCM_IDX_MAX});
		o.idx = ix[6:0];
		return o;
	endfunction
	// next-state logic: bus slave, synthesizer, playback and pwm in one pass
	always_comb begin
		logic [31:0]       rd_word;
		logic [7:0]        cur_byte;
		logic [32:0]       acc_sum;
		logic [31:0]       rate_eff;
		logic              tick;
		logic [31:0]       m;
		logic signed [15:0] syn_scaled;
		logic signed [15:0] pb_scaled;
		logic signed [8:0]  mix;
		r_next = r_reg;
		mem_we = 1'b0;
		rd_word = mem[r_reg.ptr[RAM_AW-1:2]];
		cur_byte = 8'(rd_word >> {r_reg.ptr[1:0], 3'b000});
		m = 32'h0000_0000;
		rate_eff = (r_reg.pb_rate > CLK_HZ_W) ? CLK_HZ_W : r_reg.pb_rate;
		acc_sum = {1'b0, r_reg.rate_acc} + {1'b0, rate_eff};
		tick = r_reg.pb_active && (acc_sum >= {1'b0, CLK_HZ_W});
		r_next.rate_acc = tick ? 32'(acc_sum - {1'b0, CLK_HZ_W}) : 32'(acc_sum);
		if (tick) begin
			unique case (r_reg.pb_format)
				audio_engine_pkg::format_mulaw8: r_next.pb_sample = mulaw(cur_byte);
				audio_engine_pkg::format_adpcm4: begin
					r_next.adpcm = adpcm(r_reg.adpcm,
						r_reg.nibble_hi ? cur_byte[7:4] : cur_byte[3:0]);
					r_next.pb_sample = $signed(r_next.adpcm.pred[15:8]);
					r_next.nibble_hi = ~r_reg.nibble_hi;
				end
				default: r_next.pb_sample = $signed(cur_byte ^ 8'h80);
			endcase
			if (r_reg.pb_format != audio_engine_pkg::format_adpcm4 || r_reg.nibble_hi) begin
				r_next.ptr = r_reg.ptr + 32'h0000_0001;
				r_next.remaining = r_reg.remaining - 32'h0000_0001;
				if (r_reg.remaining == 32'h0000_0001) begin
					if (r_reg.pb_loop) begin
						r_next.ptr = r_reg.pb_start;
						r_next.remaining = r_reg.pb_length;
						r_next.adpcm = '0;
					end else begin
						r_next.pb_active = 1'b0;
					end
				end
			end
		end
		if (!r_reg.pb_active) begin
			r_next.rate_acc = 32'h0000_0000;
		end

		r_next.phase = r_reg.phase + ((r_reg.effect_select[7:0] <= `CODE_PITCH_MAX)
			? note_inc(r_reg.effect_select[15:8]) : `FIXED_TONE_INC);
		if (!r_reg.effect_play) begin
			r_next.synth_sample = 8'sh00;
		end else if (r_reg.effect_select[7:0] <= `CODE_PITCH_MAX) begin
			r_next.synth_sample = sine16(r_reg.phase[23:20]);
		end else begin
			r_next.synth_sample = r_reg.phase[23] ? 8'sh9C : 8'sh64;
			r_next.effect_timer = r_reg.effect_timer - 32'h0000_0001;
			if (r_reg.effect_timer <= 32'h0000_0001) begin
				r_next.effect_play = 1'b0;
			end
		end

		// axi write channels, either order, one write in flight
		if (r_reg.bvalid && bready) begin
			r_next.bvalid = 1'b0;
		end
		if (awvalid && r_reg.awready) begin
			r_next.aw_got = 1'b1;
			r_next.waddr = awaddr;
		end
		if (wvalid && r_reg.wready) begin
			r_next.w_got = 1'b1;
			r_next.wdata = wdata;
			r_next.wstrb = wstrb;
		end
		if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = `RESP_OKAY;
			m = merge(32'h0000_0000, r_reg.wdata, r_reg.wstrb);
			if (r_reg.waddr[`RAM_SELECT_BIT]) begin
				mem_we = 1'b1;
			end else begin
				unique case (r_reg.waddr & 13'h1FFC)
					`OFS_EFFECT_SELECT: r_next.effect_select =
						16'(merge({16'h0000, r_reg.effect_select}, r_reg.wdata, r_reg.wstrb));
					`OFS_EFFECT_VOLUME: r_next.effect_volume = 8'(merge(
						{24'h000000, r_reg.effect_volume}, r_reg.wdata, r_reg.wstrb));
					`OFS_PB_START: r_next.pb_start = merge(r_reg.pb_start, r_reg.wdata,
						r_reg.wstrb);
					`OFS_PB_LENGTH: r_next.pb_length = merge(r_reg.pb_length, r_reg.wdata,
						r_reg.wstrb);
					`OFS_PB_RATE: r_next.pb_rate = merge(r_reg.pb_rate, r_reg.wdata,
						r_reg.wstrb);
					`OFS_PB_FORMAT: if (r_reg.wstrb[0]) r_next.pb_format =
						audio_engine_pkg::format_t'(r_reg.wdata[1:0]);
					`OFS_PB_LOOP: if (r_reg.wstrb[0]) r_next.pb_loop = r_reg.wdata[0];
					`OFS_PB_VOLUME: if (r_reg.wstrb[0]) r_next.pb_volume = r_reg.wdata[7:0];
					`OFS_EFFECT_PLAY: begin
						if (m[0]) begin
							// restart cuts old; code 0 is silence
							r_next.effect_play = (r_reg.effect_select[7:0] != `CODE_SILENCE);
							r_next.phase = 24'h000000;
							r_next.effect_timer = EFFECT_LEN;
						end
					end
					`OFS_PB_TRIGGER: begin
						r_next.ptr = r_reg.pb_start;
						r_next.remaining = r_reg.pb_length;
						r_next.pb_active = (r_reg.pb_length != 32'h0000_0000);
						r_next.nibble_hi = 1'b0;
						r_next.rate_acc = 32'h0000_0000;
						r_next.adpcm = '0;
					end
					`OFS_PB_FETCH_PTR: ;
					default: r_next.bresp = `RESP_DECERR;
				endcase
			end
		end
		r_next.awready = !r_next.aw_got && !r_next.bvalid;
		r_next.wready = !r_next.w_got && !r_next.bvalid;

		// axi read channel, data captured at address acceptance
		if (r_reg.rvalid && rready) begin
			r_next.rvalid = 1'b0;
		end
		if (arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = `RESP_OKAY;
			if (araddr[`RAM_SELECT_BIT]) begin
				r_next.rdata = mem[araddr[RAM_AW-1:2]];
			end else begin
				unique case (araddr & 13'h1FFC)
					`OFS_EFFECT_SELECT: r_next.rdata = {16'h0000, r_reg.effect_select};
					`OFS_EFFECT_PLAY: r_next.rdata = {31'h0, r_reg.effect_play};
					`OFS_EFFECT_VOLUME: r_next.rdata = {24'h000000, r_reg.effect_volume};
					`OFS_PB_START: r_next.rdata = r_reg.pb_start;
					`OFS_PB_LENGTH: r_next.rdata = r_reg.pb_length;
					`OFS_PB_RATE: r_next.rdata = r_reg.pb_rate;
					`OFS_PB_FORMAT: r_next.rdata = {30'h0, r_reg.pb_format};
					`OFS_PB_LOOP: r_next.rdata = {31'h0, r_reg.pb_loop};
					`OFS_PB_TRIGGER: r_next.rdata = {31'h0, r_reg.pb_active};
					`OFS_PB_VOLUME: r_next.rdata = {24'h000000, r_reg.pb_volume};
					`OFS_PB_FETCH_PTR: r_next.rdata = r_reg.ptr;
					default: begin
						r_next.rdata = 32'h0000_0000;
						r_next.rresp = `RESP_DECERR;
					end
				endcase
			end
		end
		r_next.arready = !r_next.rvalid;
		syn_scaled = r_reg.synth_sample * $signed({8'h00, r_reg.effect_volume});
		pb_scaled = r_reg.pb_sample * $signed({8'h00, r_reg.pb_volume});
		// halve the sum so both sources at full scale never clip
		mix = $signed({syn_scaled[15], syn_scaled[15:8]})
			+ $signed({pb_scaled[15], pb_scaled[15:8]});
		r_next.pwm_cnt = r_reg.pwm_cnt + 8'h01;
		if (r_reg.pwm_cnt == 8'hFF) begin
			r_next.pwm_level = mix[8:1] ^ 8'h80;
		end
		// level latched per period to avoid glitches mid-pulse
		r_next.pwm_out = (r_reg.pwm_cnt < r_reg.pwm_level);
	end
	// state register; ram contents are not reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.effect_volume <= `VOLUME_RESET;
			r_reg.pb_volume <= `VOLUME_RESET;
			r_reg.pwm_level <= 8'h80;
		end else begin
			r_reg <= r_next;
		end
	end

	// byte-lane writes into sample ram, one process so the array has a single writer
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			for (int b = 0; b < 4; b++) begin
				if (r_reg.wstrb[b]) begin
					mem[r_reg.waddr[RAM_AW-1:2]][b*8 +: 8] <= r_reg.wdata[b*8 +: 8];
				end
			end
		end
	end
	// outputs come straight from the state register
	assign awready = r_reg.awready;
	assign wready = r_reg.wready;
	assign bvalid = r_reg.bvalid;
	assign bresp = r_reg.bresp;
	assign arready = r_reg.arready;
	assign rvalid = r_reg.rvalid;
	assign rdata = r_reg.rdata;
	assign rresp = r_reg.rresp;
	assign audio_pwm = r_reg.pwm_out;
endmodule
`default_nettype wire

// [audio_engine_assertions.sv]
// port checker for the audio engine, bound into the design
`timescale 1ns/1ps
`default_nettype none
module audio_engine_checker (
	input wire logic        aclk,      // clock
	input wire logic        aresetn,   // reset, low
	input wire logic        awvalid,   // aw valid
	input wire logic        awready,   // aw ready
	input wire logic        wvalid,    // w valid
	input wire logic        wready,    // w ready
	input wire logic        bvalid,    // b valid
	input wire logic        bready,    // b ready
	input wire logic [12:0] araddr,    // read address
	input wire logic        arvalid,   // ar valid
	input wire logic        arready,   // ar ready
	input wire logic [31:0] rdata,     // read data
	input wire logic [1:0]  rresp,     // read response
	input wire logic        rvalid,    // r valid
	input wire logic        rready,    // r ready
	input wire logic        audio_pwm  // pwm pin
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// cycles since the last pwm rise, modulo one 256 clock period
	logic [7:0] gap_reg;
	logic       seen_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_reg  <= 8'h00;
			seen_reg <= 1'b0;
		end else if ($rose(audio_pwm)) begin
			gap_reg  <= 8'h00;
			seen_reg <= 1'b1;
		end else begin
			gap_reg  <= gap_reg + 8'h01;
		end
	end

	chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer missing");
	chk_write_busy: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answer pending");
	chk_write_close: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not reopened");
	chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer missing");
	chk_read_close: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer not withdrawn");
	chk_read_unmapped: assert property (arvalid && arready && araddr < 13'h1000
		&& araddr[11:0] > 12'h02B |=> rresp == 2'b11 && rdata == 32'h00000000)
		else $error("unmapped read not refused");
	chk_read_mapped: assert property (arvalid && arready && araddr < 13'h002C |=> rresp == 2'b00)
		else $error("mapped read refused");
	chk_reset_quiet: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !audio_pwm)
		else $error("outputs active after reset");
	chk_pwm_period: assert property ($rose(audio_pwm) && seen_reg |-> gap_reg == 8'hFF)
		else $error("pwm period not 256 clocks");

	cover property (bvalid && bready);
	cover property (rvalid && rready && rresp == 2'b11);
	cover property ($rose(audio_pwm));
endmodule

bind audio_engine audio_engine_checker chk_u (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .audio_pwm
);
`default_nettype wire

// [audio_filter_model.sv]
// filter model: averages the pwm pin over one pwm period
`timescale 1ns/1ps
`default_nettype none
module audio_filter_model (
	input  wire logic       aclk,    // system clock
	input  wire logic       aresetn, // reset, low
	input  wire logic       pwm_in,  // pwm pin
	output var  logic [8:0] level    // high cycles per window
);
	logic [7:0] win_reg;
	logic [8:0] acc_reg;

	// pwm averaging
	// a window of 256 clocks spans one pwm period, so a steady level reads exactly
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			win_reg <= 8'h00;
			acc_reg <= 9'h000;
			level   <= 9'h000;
		end else begin
			win_reg <= win_reg + 8'h01;
			if (win_reg == 8'hFF) begin
				level   <= acc_reg + {8'h00, pwm_in};
				acc_reg <= 9'h000;
			end else begin
				acc_reg <= acc_reg + {8'h00, pwm_in};
			end
		end
	end
endmodule
`default_nettype wire

// [audio_synth_playback_engine_test.sv]
// self-checking bench for the audio engine and its filter
`timescale 1ns/1ps
`default_nettype none
`include "audio_engine_consts.svh"
module audio_synth_playback_engine_test;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [12:0] awaddr  = 13'h0000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h00000000;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b1;  // answers always accepted
	logic [12:0] araddr  = 13'h0000;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid, audio_pwm;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [8:0]  level;
	int          num_errors = 0;
	int          num_checks = 0;
	int          cyc        = 0;

	// short effect length keeps fixed effects within a few hundred clocks
	audio_engine #(.EFFECT_CYCLES(200)) dut_u (
		.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .audio_pwm
	);
	audio_filter_model filt_u (.aclk, .aresetn, .pwm_in(audio_pwm), .level);

	always #12.5 aclk = ~aclk;

	// hang guard, well above the roughly 19000 clocks needed
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// address and data are offered together, each released when taken
	task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!wready);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (!bvalid);
		cmp("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	task automatic rdchk(input string n, input logic [12:0] a, input logic [31:0] e,
			input logic [1:0] er = 2'b00);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		cmp(n, e, d);
		cmp("rresp", {30'h0, er}, {30'h0, r});
	endtask

	// sample period is 40 clocks at this rate
	task automatic pb_setup(input logic [31:0] s, input logic [31:0] n, input logic [31:0] f,
			input logic [31:0] lp);
		wr(`OFS_PB_START, s);
		wr(`OFS_PB_LENGTH, n);
		wr(`OFS_PB_RATE, 32'h000F4240);
		wr(`OFS_PB_FORMAT, f);
		wr(`OFS_PB_LOOP, lp);
	endtask

	// reset values, select width, read-only pointer, unmapped place
	task automatic t_regs();
		rdchk("ev_vol", `OFS_EFFECT_VOLUME, 32'h000000FF);
		rdchk("pb_vol", `OFS_PB_VOLUME, 32'h000000FF);
		rdchk("play", `OFS_EFFECT_PLAY, 32'h00000000);
		rdchk("trig", `OFS_PB_TRIGGER, 32'h00000000);
		wr(`OFS_EFFECT_SELECT, 32'hABCD1234);
		rdchk("select", `OFS_EFFECT_SELECT, 32'h00001234);
		wr(`OFS_PB_FETCH_PTR, 32'h00000055);
		rdchk("ptr_ro", `OFS_PB_FETCH_PTR, 32'h00000000);
		wr(13'h0030, 32'h00000001, 2'b11);
		rdchk("unmapped", 13'h0030, 32'h00000000, 2'b11);
	endtask

	// fixed and endless effects, volume, cut-off and silence
	task automatic t_effects();
		wt(600);
		cmp("idle_lvl", 32'h00000080, {23'h0, level});
		wr(`OFS_EFFECT_SELECT, 32'h00001240);
		wr(`OFS_EFFECT_PLAY, 32'h00000001);
		rdchk("fx_on", `OFS_EFFECT_PLAY, 32'h00000001);
		wt(300);
		rdchk("fx_end", `OFS_EFFECT_PLAY, 32'h00000000);
		wr(`OFS_EFFECT_SELECT, 32'h00000C01);
		wr(`OFS_EFFECT_PLAY, 32'h00000001);
		wt(10000);
		rdchk("fx_endless", `OFS_EFFECT_PLAY, 32'h00000001);
		cmp("synth_lvl", 32'h00000001, {31'h0, level != 9'h080});
		wr(`OFS_EFFECT_VOLUME, 32'h00000000);
		wt(600);
		cmp("synth_mute", 32'h00000080, {23'h0, level});
		wr(`OFS_EFFECT_VOLUME, 32'h000000FF);
		wr(`OFS_EFFECT_SELECT, 32'h00000040);
		wr(`OFS_EFFECT_PLAY, 32'h00000001);
		wt(300);
		rdchk("fx_cut", `OFS_EFFECT_PLAY, 32'h00000000);
		wr(`OFS_EFFECT_SELECT, 32'h00000001);
		wr(`OFS_EFFECT_PLAY, 32'h00000001);
		wr(`OFS_EFFECT_SELECT, 32'h00000000);
		wr(`OFS_EFFECT_PLAY, 32'h00000001);
		rdchk("fx_silence", `OFS_EFFECT_PLAY, 32'h00000000);
	endtask

	// one-shot clips: adpcm takes two samples per byte, low nibble first
	task automatic t_once();
		wr(13'h1004, 32'hFFFFFFFF);
		rdchk("ram", 13'h1004, 32'hFFFFFFFF);
		pb_setup(32'h00000004, 32'h00000002, 32'h00000000, 32'h00000000);
		wr(`OFS_PB_TRIGGER, 32'h00000000);
		rdchk("pb_on", `OFS_PB_TRIGGER, 32'h00000001);
		wt(150);
		rdchk("pb_off", `OFS_PB_TRIGGER, 32'h00000000);
		rdchk("pb_ptr", `OFS_PB_FETCH_PTR, 32'h00000006);
		wr(`OFS_PB_FORMAT, 32'h00000002);
		wr(`OFS_PB_TRIGGER, 32'h00000001);
		wt(100);
		rdchk("adpcm_mid", `OFS_PB_FETCH_PTR, 32'h00000005);
		wt(150);
		rdchk("adpcm_off", `OFS_PB_TRIGGER, 32'h00000000);
		rdchk("adpcm_ptr", `OFS_PB_FETCH_PTR, 32'h00000006);
	endtask

	// looping clip of one word runs until loop is cleared; volume scales it
	task automatic t_loop(input logic [31:0] f, input logic [31:0] w, input logic loud);
		logic [31:0] d;
		logic [1:0]  r;
		wr(13'h1008, w);
		pb_setup(32'h00000008, 32'h00000004, f, 32'h00000001);
		wr(`OFS_PB_TRIGGER, 32'h00000001);
		wt(600);
		rdchk("loop_on", `OFS_PB_TRIGGER, 32'h00000001);
		rd(`OFS_PB_FETCH_PTR, d, r);
		cmp("loop_ptr", 32'h00000001, {31'h0, d >= 32'h8 && d < 32'hC});
		if (loud)
			cmp("pb_loud", 32'h00000001, {31'h0, level > 9'h0A0});
		else
			cmp("pb_zero", 32'h00000080, {23'h0, level});
		wr(`OFS_PB_VOLUME, 32'h00000000);
		wt(600);
		cmp("pb_mute", 32'h00000080, {23'h0, level});
		wr(`OFS_PB_VOLUME, 32'h000000FF);
		wr(`OFS_PB_LOOP, 32'h00000000);
		wt(400);
		rdchk("loop_off", `OFS_PB_TRIGGER, 32'h00000000);
		rdchk("loop_end", `OFS_PB_FETCH_PTR, 32'h0000000C);
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_effects();
		t_once();
		t_loop(32'h00000000, 32'hFFFFFFFF, 1'b1);
		t_loop(32'h00000001, 32'hFFFFFFFF, 1'b0);
		t_loop(32'h00000001, 32'h80808080, 1'b1);
		t_loop(32'h00000002, 32'h00000000, 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
